/* logic/ccp_clock_power.sv */
module ccp_clock_power
	import ccp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire ccp_wb_req_t wb_req,
	output ccp_wb_rsp_t      wb_rsp,
	input  wire logic [7:0]  user_config_byte,
	input  wire logic        clock_in_pin,
	input  wire logic        brownout_det,
	input  wire logic        power_on_det,
	input  wire logic        watchdog_overflow,
	input  wire logic        irq_pending,
	input  wire logic        wake_irq,
	input  wire logic        brownout_irq_ack,
	output logic             cpu_clk_en,
	output logic             machine_cycle_en,
	output logic             cpu_run,
	output logic             osc_run,
	output logic             sys_reset,
	output logic             brownout_irq,
	output logic             clock_out_pin,
	output logic             clock_out_pin_oe,
	output logic             osc_pins_disabled
);

	ccp_state_t st;
	ccp_state_t next_st;

	// ------------------------------------------------------------
	// Decoded terms
	// ------------------------------------------------------------
	ccp_osc_t    osc_type;
	logic        is_xtal;
	logic        is_rcext;
	logic        halve;
	logic        brownout_disable;
	logic        brownout_irq_select;
	logic        ea;
	logic        brownout_irq_enable;
	logic        bo_rise;
	logic        pin_rise;
	logic        osc_tick;
	logic        half_tick;
	logic [8:0]  div_lim;
	logic        div_wrap;
	logic        cpu_tick;
	logic [10:0] stab_last;
	logic        bo_wake;
	logic        co_on;
	logic        acc;
	logic        wr;
	logic [7:0]  wbyte;
	logic [31:0] rd_mux;

	always_comb begin
		osc_type  = ccp_osc_t'(st.cfg[2:0]);
		// Only these three are crystals; any other code keeps the pins
		is_xtal   = (osc_type == OSC_LOW) || (osc_type == OSC_MED) ||
			(osc_type == OSC_HIGH);
		is_rcext  = (osc_type == OSC_RC) || (osc_type == OSC_EXT);
		halve     = st.cfg[CFG_HALVE];
		brownout_disable       = st.aux[AUX_BOD];
		brownout_irq_select       = st.aux[AUX_BOI];
		ea        = st.ien[IEN_EA];
		brownout_irq_enable       = st.ien[IEN_EBO];
		bo_rise   = st.bo_sy[1] & ~st.bo_prev & ~brownout_disable;
		// No timeout on the pin edge: a static input just stalls ticks
		pin_rise  = st.pin_sy[1] & ~st.pin_prev;
		osc_tick  = (st.pst != PS_PDOWN) &&
			((osc_type == OSC_EXT) ? pin_rise : 1'b1);
		half_tick = osc_tick & (~halve | st.half);
		div_lim   = {st.div, 1'b1};
		// Compare with >= so a smaller divisor never strands the count
		div_wrap  = (st.div == 8'h00) || (st.div_cnt >= div_lim);
		cpu_tick  = half_tick & div_wrap;
		stab_last = (is_xtal ? STAB_XTAL : STAB_RC) - 11'h001;
		bo_wake   = bo_rise & brownout_irq_select & ea & brownout_irq_enable;
		co_on     = st.p2m[P2M_CLKOUT] & is_rcext &
			(st.pst != PS_PDOWN);
		acc       = wb_req.cyc & wb_req.stb;
		wr        = acc & wb_req.we & st.ack & wb_req.sel[0];
		wbyte     = wb_req.dat[7:0];
		unique case (wb_req.adr)
		ADR_DIV:  rd_mux = {24'h000000, st.div};
		ADR_POWER_CONTROL: rd_mux = {24'h000000, st.power_control};
		ADR_AUX:  rd_mux = {24'h000000, st.aux};
		ADR_P2M:  rd_mux = {24'h000000, st.p2m};
		ADR_IEN:  rd_mux = {24'h000000, st.ien};
		ADR_STAT: rd_mux = {20'h00000, st.bo_pend, st.pins_off,
			st.pst, st.cfg};
		default:  rd_mux = 32'h00000000;
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;

		next_st.bo_sy    = {st.bo_sy[0], brownout_det};
		next_st.por_sy   = {st.por_sy[0], power_on_det};
		next_st.wdt_sy   = {st.wdt_sy[0], watchdog_overflow};
		next_st.pin_sy   = {st.pin_sy[0], clock_in_pin};
		next_st.bo_prev  = st.bo_sy[1];
		next_st.pin_prev = st.pin_sy[1];

		// Straps are caught once after reset release, then frozen
		if (!st.cfg_ok) begin
			next_st.cfg    = user_config_byte;
			next_st.cfg_ok = 1'b1;
		end

		// Bus slave: ack one cycle after request, write on the ack edge
		next_st.ack = acc & ~st.ack;
		if (acc & ~st.ack)
			next_st.rdat = rd_mux;
		if (wr) begin
			unique case (wb_req.adr)
			ADR_DIV: next_st.div = wbyte;
			ADR_POWER_CONTROL: begin
				next_st.power_control[POWER_CONTROL_IDLE] = st.power_control[POWER_CONTROL_IDLE] | wbyte[POWER_CONTROL_IDLE];
				next_st.power_control[POWER_CONTROL_PD]   = st.power_control[POWER_CONTROL_PD] | wbyte[POWER_CONTROL_PD];
				next_st.power_control[POWER_CONTROL_POF]  = st.power_control[POWER_CONTROL_POF] & wbyte[POWER_CONTROL_POF];
				next_st.power_control[POWER_CONTROL_BOF]  = st.power_control[POWER_CONTROL_BOF] & wbyte[POWER_CONTROL_BOF];
			end
			ADR_AUX: next_st.aux = wbyte;
			ADR_P2M: next_st.p2m = wbyte;
			ADR_IEN: next_st.ien = wbyte;
			default: next_st.ack = st.ack & 1'b0;
			endcase
		end

		// Sticky flags: the set follows the clear so it wins
		if (bo_rise)
			next_st.power_control[POWER_CONTROL_BOF] = 1'b1;
		if (st.por_sy[1])
			next_st.power_control[POWER_CONTROL_POF] = 1'b1;
		if (brownout_irq_ack)
			next_st.bo_pend = 1'b0;
		if (bo_rise & brownout_irq_select)
			next_st.bo_pend = 1'b1;

		next_st.bo_rst  = st.bo_sy[1] & ~brownout_disable & ~brownout_irq_select;
		next_st.sys_rst = next_st.bo_rst | st.wdt_sy[1];
		next_st.irq     = st.bo_pend & ea & brownout_irq_enable;

		// Clock chain
		if (osc_tick)
			next_st.half = ~st.half;
		if (half_tick)
			next_st.div_cnt = div_wrap ? 9'h000 : st.div_cnt + 9'h001;
		if (cpu_tick)
			next_st.mc_cnt = (st.mc_cnt == MC_LAST) ? 3'h0 :
				st.mc_cnt + 3'h1;
		next_st.cpu_en = cpu_tick;
		next_st.mc_en  = cpu_tick && (st.mc_cnt == MC_LAST);

		// Clock output: half period is three CPU clocks
		next_st.co_oe = co_on;
		if (!co_on)
			next_st.co = 1'b0;
		else if (cpu_tick && (st.mc_cnt == CO_MID ||
			st.mc_cnt == MC_LAST))
			next_st.co = ~st.co;
		next_st.pins_off = is_xtal;

		// Power modes
		unique case (st.pst)
		PS_RUN: begin
			if (st.power_control[POWER_CONTROL_PD])
				next_st.pst = PS_PDOWN;
			else if (st.power_control[POWER_CONTROL_IDLE])
				next_st.pst = PS_IDLE;
		end
		PS_IDLE: begin
			if (irq_pending) begin
				next_st.pst = PS_RUN;
				next_st.power_control[POWER_CONTROL_IDLE] = 1'b0;
			end
		end
		PS_PDOWN: begin
			next_st.stab_cnt = 11'h000;
			if (wake_irq | bo_wake) begin
				next_st.pst = PS_STAB;
				next_st.power_control[POWER_CONTROL_PD] = 1'b0;
			end
		end
		PS_STAB: begin
			if (osc_tick) begin
				next_st.stab_cnt = st.stab_cnt + 11'h001;
				if (st.stab_cnt == stab_last)
					next_st.pst = PS_RUN;
			end
		end
		endcase
		// Brownout and watchdog resets abort any mode straight away
		if (st.sys_rst) begin
			next_st.pst = PS_RUN;
			next_st.power_control[POWER_CONTROL_IDLE] = 1'b0;
			next_st.power_control[POWER_CONTROL_PD]   = 1'b0;
		end
		next_st.cpu_run = (next_st.pst == PS_RUN) & ~next_st.sys_rst;
		next_st.osc_run = (next_st.pst != PS_PDOWN);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st      <= '0;
			st.div  <= DIV_RST;
			st.power_control <= POWER_CONTROL_RST;
			st.aux  <= AUX_RST;
			st.p2m  <= P2M_RST;
			st.ien  <= IEN_RST;
			st.pst  <= PS_RUN;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign wb_rsp.ack        = st.ack;
	assign wb_rsp.dat        = st.rdat;
	assign cpu_clk_en        = st.cpu_en;
	assign machine_cycle_en  = st.mc_en;
	assign cpu_run           = st.cpu_run;
	assign osc_run           = st.osc_run;
	assign sys_reset         = st.sys_rst;
	assign brownout_irq      = st.irq;
	assign clock_out_pin     = st.co;
	assign clock_out_pin_oe  = st.co_oe;
	assign osc_pins_disabled = st.pins_off;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_halve_gap;
		st.cfg_ok && halve && st.div == 8'h00 && cpu_tick |=> !cpu_tick;
	endproperty
	a_halve_gap: assert property (p_halve_gap)
		else $error("halved clock ticked twice in a row");

	property p_full_rate;
		st.cfg_ok && !halve && st.div == 8'h00 && osc_type != OSC_EXT &&
			st.pst == PS_RUN |-> cpu_tick;
	endproperty
	a_full_rate: assert property (p_full_rate)
		else $error("undivided clock missed a tick");

	property p_div_bound;
		st.div != 8'h00 && half_tick && st.div_cnt < div_lim |=>
			!st.cpu_en;
	endproperty
	a_div_bound: assert property (p_div_bound)
		else $error("divided clock ticked early");

	property p_bof_set;
		bo_rise |=> st.power_control[POWER_CONTROL_BOF];
	endproperty
	a_bof_set: assert property (p_bof_set)
		else $error("brownout flag not set");

	property p_bod_quiet;
		brownout_disable && $past(brownout_disable) |=> !st.bo_rst && !bo_rise;
	endproperty
	a_bod_quiet: assert property (p_bod_quiet)
		else $error("disabled brownout still acted");

	property p_bo_hold;
		st.bo_sy[1] && !brownout_disable && !brownout_irq_select |=> st.bo_rst && sys_reset;
	endproperty
	a_bo_hold: assert property (p_bo_hold)
		else $error("brownout reset not held");

	property p_pd_stops;
		st.pst == PS_PDOWN |=> !osc_run || st.pst != PS_PDOWN;
	endproperty
	a_pd_stops: assert property (p_pd_stops)
		else $error("oscillator ran in power-down");

	property p_stab_hold;
		st.pst == PS_STAB |-> !cpu_run;
	endproperty
	a_stab_hold: assert property (p_stab_hold)
		else $error("execution resumed before stable");

	property p_idle_clear;
		st.pst == PS_IDLE && irq_pending |=>
			!st.power_control[POWER_CONTROL_IDLE] && st.pst == PS_RUN;
	endproperty
	a_idle_clear: assert property (p_idle_clear)
		else $error("idle request not cleared on exit");

	property p_co_gate;
		clock_out_pin_oe |-> $past(is_rcext);
	endproperty
	a_co_gate: assert property (p_co_gate)
		else $error("clock output driven with crystal");

	property p_co_on;
		co_on |=> clock_out_pin_oe;
	endproperty
	a_co_on: assert property (p_co_on)
		else $error("clock output not driven");

	property p_co_rate;
		co_on && $past(co_on) && cpu_tick && st.mc_cnt == CO_MID |=>
			clock_out_pin != $past(clock_out_pin);
	endproperty
	a_co_rate: assert property (p_co_rate)
		else $error("clock output missed a toggle");

	property p_mc_pulse;
		cpu_tick && st.mc_cnt == MC_LAST |=> machine_cycle_en;
	endproperty
	a_mc_pulse: assert property (p_mc_pulse)
		else $error("machine cycle pulse missing");

	property p_pof_set;
		st.por_sy[1] |=> st.power_control[POWER_CONTROL_POF];
	endproperty
	a_pof_set: assert property (p_pof_set)
		else $error("power-on flag not set");

	property p_bo_pend;
		bo_rise && brownout_irq_select |=> st.bo_pend;
	endproperty
	a_bo_pend: assert property (p_bo_pend)
		else $error("brownout interrupt not pending");

	property p_irq_gate;
		brownout_irq |-> $past(ea) && $past(brownout_irq_enable);
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("brownout interrupt without enables");

	property p_boi_no_rst;
		brownout_irq_select |=> !st.bo_rst;
	endproperty
	a_boi_no_rst: assert property (p_boi_no_rst)
		else $error("brownout reset in interrupt mode");

	property p_idle_enter;
		st.pst == PS_RUN && st.power_control[POWER_CONTROL_IDLE] && !st.power_control[POWER_CONTROL_PD] &&
			!st.sys_rst |=> st.pst == PS_IDLE && !cpu_run;
	endproperty
	a_idle_enter: assert property (p_idle_enter)
		else $error("idle request ignored");

	property p_pd_enter;
		st.pst == PS_RUN && st.power_control[POWER_CONTROL_PD] && !st.sys_rst |=> !osc_run;
	endproperty
	a_pd_enter: assert property (p_pd_enter)
		else $error("oscillator kept running after power-down");

	property p_wake;
		st.pst == PS_PDOWN && wake_irq && !st.sys_rst |=>
			st.pst == PS_STAB && !st.power_control[POWER_CONTROL_PD];
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake interrupt did not leave power-down");

	property p_wdt_rst;
		st.wdt_sy[1] |=> sys_reset;
	endproperty
	a_wdt_rst: assert property (p_wdt_rst)
		else $error("watchdog overflow gave no reset");

	property p_rst_exit;
		st.sys_rst |=> st.pst == PS_RUN;
	endproperty
	a_rst_exit: assert property (p_rst_exit)
		else $error("reset did not end the power mode");

	property p_pins_off;
		st.cfg_ok && is_xtal |=> osc_pins_disabled;
	endproperty
	a_pins_off: assert property (p_pins_off)
		else $error("crystal pins left enabled");

	property p_stab_exit;
		st.pst == PS_STAB && osc_tick && st.stab_cnt == stab_last &&
			!st.sys_rst |=> cpu_run;
	endproperty
	a_stab_exit: assert property (p_stab_exit)
		else $error("execution did not resume after count");

endmodule // ccp_clock_power

/* logic/ccp_pkg.sv */
package ccp_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_DIV  = 8'h00;
	localparam logic [7:0] ADR_POWER_CONTROL = 8'h04;
	localparam logic [7:0] ADR_AUX  = 8'h08;
	localparam logic [7:0] ADR_P2M  = 8'h0C;
	localparam logic [7:0] ADR_IEN  = 8'h10;
	localparam logic [7:0] ADR_STAT = 8'h14;

	localparam int POWER_CONTROL_IDLE  = 0;
	localparam int POWER_CONTROL_PD    = 1;
	localparam int POWER_CONTROL_POF   = 4;
	localparam int POWER_CONTROL_BOF   = 5;
	localparam int AUX_BOI    = 5;
	localparam int AUX_BOD    = 6;
	localparam int P2M_CLKOUT = 6;
	localparam int IEN_EBO    = 5;
	localparam int IEN_EA     = 7;
	localparam int CFG_HALVE  = 3;
	localparam int CFG_BOV    = 4;

	localparam logic [7:0] DIV_RST  = 8'h00;
	localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
	localparam logic [7:0] AUX_RST  = 8'h00;
	localparam logic [7:0] P2M_RST  = 8'h00;
	localparam logic [7:0] IEN_RST  = 8'h00;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam logic [10:0] STAB_XTAL = 11'h400;
	localparam logic [10:0] STAB_RC   = 11'h100;
	localparam logic [2:0]  MC_LAST   = 3'h5;
	localparam logic [2:0]  CO_MID    = 3'h2;

	typedef enum logic [2:0] {
		OSC_LOW  = 3'h0,
		OSC_MED  = 3'h1,
		OSC_HIGH = 3'h2,
		OSC_RC   = 3'h3,
		OSC_EXT  = 3'h4
	} ccp_osc_t;

	typedef enum logic [1:0] {
		PS_RUN   = 2'b00,
		PS_PDOWN = 2'b01,
		PS_STAB  = 2'b11,
		PS_IDLE  = 2'b10
	} ccp_pst_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} ccp_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} ccp_wb_rsp_t;

	typedef struct packed {
		logic [1:0]  bo_sy;
		logic [1:0]  por_sy;
		logic [1:0]  wdt_sy;
		logic [1:0]  pin_sy;
		logic        bo_prev;
		logic        pin_prev;
		logic        cfg_ok;
		logic [7:0]  cfg;
		logic [7:0]  div;
		logic [7:0]  power_control;
		logic [7:0]  aux;
		logic [7:0]  p2m;
		logic [7:0]  ien;
		logic        half;
		logic [8:0]  div_cnt;
		logic [2:0]  mc_cnt;
		logic [10:0] stab_cnt;
		ccp_pst_t    pst;
		logic        bo_pend;
		logic        bo_rst;
		logic        sys_rst;
		logic        cpu_en;
		logic        mc_en;
		logic        cpu_run;
		logic        osc_run;
		logic        co;
		logic        co_oe;
		logic        pins_off;
		logic        irq;
		logic        ack;
		logic [31:0] rdat;
	} ccp_state_t;

endpackage

/* test/ccp_clock_power_tb.sv */
module ccp_clock_power_tb
	import ccp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// --------
	// Signals
	// --------
	logic		clk, nrst, bo, por, wdt, irqp, wake, back, go;
	logic		cen, mce, run, osc, srst, boirq, co, cooe, pdis, pin;
	logic [7:0]	q;
	logic [7:0]	cfg;
	logic [2:0]	mon;
	ccp_wb_req_t	req;
	ccp_wb_rsp_t	rsp;
	int		err_total, checked, n;

	assign mon = {mce, co, cen};

	ccp_clock_power DUT (
		.clk			(clk),
		.nrst			(nrst),
		.wb_req			(req),
		.wb_rsp			(rsp),
		.user_config_byte	(cfg),
		.clock_in_pin		(pin),
		.brownout_det		(bo),
		.power_on_det		(por),
		.watchdog_overflow	(wdt),
		.irq_pending		(irqp),
		.wake_irq		(wake),
		.brownout_irq_ack	(back),
		.cpu_clk_en		(cen),
		.machine_cycle_en	(mce),
		.cpu_run		(run),
		.osc_run		(osc),
		.sys_reset		(srst),
		.brownout_irq		(boirq),
		.clock_out_pin		(co),
		.clock_out_pin_oe	(cooe),
		.osc_pins_disabled	(pdis)
	);

	ccp_ext_osc xosc (
		.go	(go),
		.pin	(pin)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#200000;
		err_total++;
		results();
	end

	// --------
	// Helpers
	// --------
	task results;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %0h got %0h", s, e, g);
		end
	endtask

	// Config byte is a strap of its own, apart from the bus read holder
	task rst(input logic [7:0] c);
		@(posedge clk);
		nrst <= 1'b0;
		cfg <= c;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int t;
		t = 0;
		@(posedge clk);
		req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
		do begin
			@(posedge clk);
			t++;
		end while (rsp.ack !== 1'b1 && t < 50);
		chk("ack", 1, rsp.ack);
		q = rsp.dat[7:0];
		req <= '0;
	endtask

	task rd(input string s, input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(s, e, q);
	endtask

	task tick(input int k);
		repeat (k) @(posedge clk);
	endtask

	// Sampled mid-cycle so edge updates have landed
	task cnt(input int w, output int c);
		c = 0;
		repeat (w) begin
			@(negedge clk);
			if (cen === 1'b1) c++;
		end
	endtask

	task len(input int i, input logic v, output int c);
		int t;
		c = 0;
		t = 0;
		while (mon[i] === v && t < 3000) begin
			@(negedge clk);
			t++;
		end
		while (mon[i] !== v && t < 3000) begin
			@(negedge clk);
			t++;
		end
		while (mon[i] === v && t < 3000) begin
			@(negedge clk);
			t++;
			c++;
		end
	endtask

	task wr(output int c);
		c = 0;
		while (run !== 1'b1 && c < 3000) begin
			@(posedge clk);
			c++;
		end
	endtask

	// --------
	// Scenarios
	// --------
	task t_regs;
		wb(1'b1, ADR_STAT, 8'hFF);
		for (int i = 0; i < 9; i++) begin
			rd("reg", 8'(4 * i), (i == 5) ? 8'h03 : 8'h00);
		end
		chk("pins", 0, pdis);
	endtask

	task t_div;
		cnt(40, n);
		chk("div0", 40, n);
		len(2, 1'b0, n);
		chk("mcyc", 5, n);
		wb(1'b1, ADR_DIV, 8'h01);
		chk("run", 1, run);
		len(0, 1'b0, n);
		chk("div1", 3, n);
		wb(1'b1, ADR_DIV, 8'hFF);
		len(0, 1'b0, n);
		chk("div255", 511, n);
		wb(1'b1, ADR_DIV, 8'h00);
	endtask

	task t_co_idle;
		chk("oe_off", 0, cooe);
		wb(1'b1, ADR_P2M, 8'h40);
		tick(3);
		chk("oe", 1, cooe);
		len(1, 1'b1, n);
		chk("co", 3, n);
		wb(1'b1, ADR_POWER_CONTROL, 8'h01);
		tick(3);
		chk("idle", 0, run);
		len(1, 1'b1, n);
		chk("co_idle", 3, n);
		irqp <= 1'b1;
		tick(1);
		irqp <= 1'b0;
		tick(3);
		chk("unidle", 1, run);
		rd("idl_clr", ADR_POWER_CONTROL, 8'h00);
		wb(1'b1, ADR_P2M, 8'h00);
	endtask

	task t_bo;
		bo <= 1'b1;
		tick(8);
		chk("bor", 1, srst);
		tick(30);
		chk("bor_hold", 1, srst);
		bo <= 1'b0;
		tick(8);
		chk("bor_end", 0, srst);
		rd("bof", ADR_POWER_CONTROL, 8'h20);
		wb(1'b1, ADR_POWER_CONTROL, 8'h00);
		rd("bof_clr", ADR_POWER_CONTROL, 8'h00);
		wb(1'b1, ADR_AUX, 8'h40);
		bo <= 1'b1;
		tick(8);
		chk("bod_rst", 0, srst);
		chk("bod_irq", 0, boirq);
		bo <= 1'b0;
		tick(8);
		wb(1'b1, ADR_IEN, 8'hA0);
		wb(1'b1, ADR_AUX, 8'h20);
		wb(1'b1, ADR_POWER_CONTROL, 8'h02);
		tick(3);
		chk("pd_osc", 0, osc);
		bo <= 1'b1;
		tick(8);
		chk("boi_rst", 0, srst);
		chk("boi", 1, boirq);
		back <= 1'b1;
		tick(1);
		back <= 1'b0;
		tick(20);
		chk("boi_once", 0, boirq);
		wr(n);
		chk("boi_wake", 1, n < 300);
		bo <= 1'b0;
		tick(8);
		wb(1'b1, ADR_IEN, 8'h00);
		wb(1'b1, ADR_AUX, 8'h00);
		wb(1'b1, ADR_POWER_CONTROL, 8'h00);
	endtask

	task t_pd(input int k);
		wb(1'b1, ADR_POWER_CONTROL, 8'h02);
		tick(20);
		chk("pd_osc", 0, osc);
		chk("pd_run", 0, run);
		wake <= 1'b1;
		tick(1);
		wake <= 1'b0;
		wr(n);
		chk("stab", 1, n >= k && n <= k + 6);
		rd("pd_clr", ADR_POWER_CONTROL, 8'h00);
	endtask

	task t_wdt_por;
		wb(1'b1, ADR_POWER_CONTROL, 8'h02);
		tick(3);
		wdt <= 1'b1;
		tick(6);
		chk("wdt", 1, srst);
		wdt <= 1'b0;
		tick(10);
		chk("wdt_run", 1, run);
		rd("wdt_pd", ADR_POWER_CONTROL, 8'h00);
		por <= 1'b1;
		tick(3);
		por <= 1'b0;
		tick(20);
		rd("pof", ADR_POWER_CONTROL, 8'h10);
		wb(1'b1, ADR_POWER_CONTROL, 8'h00);
		rd("pof_clr", ADR_POWER_CONTROL, 8'h00);
	endtask

	task t_ext;
		chk("pins_e", 0, pdis);
		go <= 1'b1;
		tick(1);
		go <= 1'b0;
		cnt(300, n);
		chk("ext", 10, n);
		cnt(100, n);
		chk("ext_stop", 0, n);
	endtask

	initial begin
		{nrst, bo, por, wdt, irqp, wake, back, go} = '0;
		req = '0;
		cfg = 8'h03;
		err_total = 0;
		checked = 0;
		rst(8'h03);
		t_regs();
		t_div();
		t_co_idle();
		t_bo();
		t_pd(256);
		t_wdt_por();
		rst(8'h08);
		chk("pins_x", 1, pdis);
		cnt(40, n);
		chk("half", 20, n);
		len(2, 1'b0, n);
		chk("mcyc12", 11, n);
		t_pd(1024);
		rst(8'h04);
		t_ext();
		results();
	end

endmodule // ccp_clock_power_tb

/* test/ccp_ext_osc.sv */
module ccp_ext_osc #(
	parameter int BURST = 10
) (
	input  wire logic go,
	output logic      pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// --------
	// Source
	// --------
	// Bursts at 10 MHz, then static low: a stopped clock is legal
	initial begin
		pin = 1'b0;
		forever begin
			@(posedge go);
			repeat (BURST) begin
				#50 pin = 1'b1;
				#50 pin = 1'b0;
			end
		end
	end

endmodule // ccp_ext_osc
